// [hdl/power_resource_sequencer.sv]
/*
 * power resource sequencer: enable pins, regulator controls, resource
 * state machines with dependency table, sleep/retention control and an
 * AXI4-Lite register slave. assumes pins already synchronous to aclk.
 */
`timescale 1ns/1ns
// Contract
// RULE1 - regulators on when either pin high
// RULE2 - wlan section reset follows its pin
// RULE3 - core regulators power up on any pin; here only the core switching regulator is forced on, core ldo waits for demand
// RULE4 - core and low-noise ldo follow demand
// RULE5 - request merges clocks, mask, timers
// RULE6 - clock requests mapped to resources first
// RULE7 - each resource in exactly one state
// RULE8 - timer zero when stable, nonzero transitioning
// RULE9 - timer loaded with on or off delay
// RULE10 - timer decrements each low-power tick
// RULE11 - zero delay means immediate transition
// RULE12 - required set recomputed every tick
// RULE13 - timer zero clears pending, toggles state
// RULE14 - disable unrequested resource without powered dependents
// RULE15 - enable requested resource with dependencies on
// RULE16 - doze keeps only low-power clock running
// RULE17 - save core state before deep sleep
// RULE18 - restore core state on wake event
// RULE19 - host wakes power-down by raising pin
// RULE20 - shutdown tristates outputs, disables inputs
// RULE21 - power-up from shutdown is cold start
// RULE22 - pin pull-downs on after reset, software off
// RULE23 - required set closed over dependencies
// RULE24 - delays writable, state flags readable
module power_resource_sequencer #(
	parameter int NUM_CLK_REQ = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic wireless_lan_enable_pin,
	input wire logic short_range_radio_enable_pin,
	input wire logic [NUM_CLK_REQ-1:0] clk_req,
	input wire logic wake_event,
	output logic regulator_enable,
	output logic wlan_reset_n,
	output logic [prs_pkg::NUM_RES-1:0] resource_enable,
	output logic main_clk_enable,
	output logic retention_save,
	output logic retention_restore,
	output logic io_enable,
	output logic wl_pulldown_enable,
	output logic sr_pulldown_enable
);
	localparam int N = prs_pkg::NUM_RES;
	localparam int DW = prs_pkg::DLY_W;
	localparam int CHK_RES = 3; // lane watched by the timer checks; the bench drives it timed

	logic [31:0] ctrl_q;
	logic [N-1:0] min_mask_q, timer_req_q;
	logic [N-1:0] clk_map_q [NUM_CLK_REQ];
	logic [N-1:0] dep_q [N];
	prs_pkg::res_dly_s dly_q [N];
	logic [DW-1:0] timer_q [N];
	logic [N-1:0] on_flag_q, pend_flag_q;
	logic [15:0] div_q;
	logic tick_q;
	logic any_pin;
	prs_pkg::pm_mode_e mode_q;

	assign any_pin = wireless_lan_enable_pin | short_range_radio_enable_pin;

	// pin-driven outputs and pull-down controls, registered; shutdown is a cold reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			regulator_enable <= 1'b0;
			wlan_reset_n <= 1'b0;
			io_enable <= 1'b0;
			wl_pulldown_enable <= 1'b1;
			sr_pulldown_enable <= 1'b1;
		end else begin
			regulator_enable <= any_pin; // [RULE1] [RULE3]
			wlan_reset_n <= wireless_lan_enable_pin; // [RULE2]
			io_enable <= any_pin; // [RULE20] [RULE19]
			wl_pulldown_enable <= ctrl_q[prs_pkg::CTRL_PD_WL]; // [RULE22]
			sr_pulldown_enable <= ctrl_q[prs_pkg::CTRL_PD_SR]; // [RULE22]
		end
	end

	// low-power tick generator; stands in for the 32.768 kHz sequencer clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (div_q == 16'(prs_pkg::TICK_DIV - 1)) begin
			div_q <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// request merge and dependency closure; fixed N passes reach fixpoint
	logic [N-1:0] clk_res, req, need;
	always_comb begin
		clk_res = '0;
		for (int c = 0; c < NUM_CLK_REQ; c++) begin
			if (clk_req[c]) clk_res = clk_res | clk_map_q[c]; // [RULE6]
		end
		req = clk_res | min_mask_q | timer_req_q; // [RULE5]
		if (!any_pin) req = '0;
		need = req;
		for (int p = 0; p < N; p++) begin
			for (int r = 0; r < N; r++) begin
				if (need[r]) need = need | dep_q[r]; // [RULE23]
			end
		end
	end

	// dependency checks per resource
	logic [N-1:0] deps_on, dependents_up;
	always_comb begin
		deps_on = '0;
		dependents_up = '0;
		for (int r = 0; r < N; r++) begin
			deps_on[r] = ((dep_q[r] & ~(on_flag_q & ~pend_flag_q)) == '0);
			for (int d = 0; d < N; d++) begin
				if (dep_q[d][r] && (on_flag_q[d] || pend_flag_q[d])) dependents_up[r] = 1'b1;
			end
		end
	end

	// resource state machines, stepped once per tick; encoding {on,pending}
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_flag_q <= '0;
			pend_flag_q <= '0;
			for (int r = 0; r < N; r++) timer_q[r] <= '0;
		end else if (tick_q) begin // [RULE12]
			for (int r = 0; r < N; r++) begin
				if (pend_flag_q[r]) begin
					if (timer_q[r] == DW'(1)) begin
						timer_q[r] <= '0;
						pend_flag_q[r] <= 1'b0; // [RULE13]
						on_flag_q[r] <= ~on_flag_q[r]; // [RULE10] [RULE13]
					end else begin
						timer_q[r] <= timer_q[r] - DW'(1); // [RULE10]
					end
				end else if (on_flag_q[r] && !need[r] && !dependents_up[r]) begin // [RULE14]
					if (dly_q[r].off_dly == '0) begin
						on_flag_q[r] <= 1'b0; // [RULE11]
					end else begin
						timer_q[r] <= dly_q[r].off_dly; // [RULE9]
						pend_flag_q[r] <= 1'b1;
					end
				end else if (!on_flag_q[r] && need[r] && deps_on[r]) begin // [RULE15]
					if (dly_q[r].on_dly == '0) begin
						on_flag_q[r] <= 1'b1; // [RULE11]
					end else begin
						timer_q[r] <= dly_q[r].on_dly; // [RULE9]
						pend_flag_q[r] <= 1'b1;
					end
				end
			end
		end
	end

	// regulator enables: on, going on or going off; core switching regulator follows the pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			resource_enable <= '0;
		end else begin
			for (int r = 0; r < N; r++) begin
				resource_enable[r] <= (on_flag_q[r] ^ pend_flag_q[r]) | pend_flag_q[r]; // [RULE4] [RULE7]
			end
			resource_enable[prs_pkg::RES_CORE_SWITCHING_REGULATOR_IDX] <= any_pin; // [RULE3]
		end
	end

	// power mode: sleep request saves state, wake restores it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= prs_pkg::PM_OFF;
			main_clk_enable <= 1'b0;
			retention_save <= 1'b0;
			retention_restore <= 1'b0;
		end else begin
			retention_save <= 1'b0;
			retention_restore <= 1'b0;
			case (mode_q)
				prs_pkg::PM_OFF: begin
					main_clk_enable <= 1'b0;
					if (any_pin) mode_q <= prs_pkg::PM_ACTIVE; // [RULE21]
				end
				prs_pkg::PM_ACTIVE: begin
					main_clk_enable <= 1'b1;
					if (!any_pin) begin
						mode_q <= prs_pkg::PM_OFF;
					end else if (ctrl_q[prs_pkg::CTRL_SLEEP]) begin
						retention_save <= 1'b1; // [RULE17]
						mode_q <= prs_pkg::PM_SAVE;
					end
				end
				prs_pkg::PM_SAVE: begin
					main_clk_enable <= 1'b0; // [RULE16]
					mode_q <= prs_pkg::PM_SLEEP;
				end
				prs_pkg::PM_SLEEP: begin
					main_clk_enable <= 1'b0; // [RULE16]
					if (!any_pin) begin
						mode_q <= prs_pkg::PM_OFF;
					end else if (wake_event) begin
						retention_restore <= 1'b1; // [RULE18]
						mode_q <= prs_pkg::PM_ACTIVE;
					end
				end
				default: mode_q <= prs_pkg::PM_OFF;
			endcase
		end
	end

	// axi write: take address and data in either order, answer after both
	logic aw_got_q, w_got_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic wr_go;
	assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= prs_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q < prs_pkg::OFF_DLY_BASE + 8'(4 * N)) ?
					prs_pkg::RESP_OKAY : prs_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes; full-word writes only, wstrb ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= prs_pkg::CTRL_RST;
			min_mask_q <= '0;
			timer_req_q <= '0;
			for (int c = 0; c < NUM_CLK_REQ; c++) clk_map_q[c] <= '0;
			for (int r = 0; r < N; r++) begin
				dep_q[r] <= '0;
				dly_q[r] <= '0;
			end
		end else if (wr_go) begin
			case (awaddr_q)
				prs_pkg::OFF_CTRL: ctrl_q <= wdata_q; // [RULE22]
				prs_pkg::OFF_MIN_MASK: min_mask_q <= wdata_q[N-1:0];
				prs_pkg::OFF_TIMER_REQ: timer_req_q <= wdata_q[N-1:0];
				prs_pkg::OFF_CLK_MAP: begin
					for (int c = 0; c < NUM_CLK_REQ; c++) clk_map_q[c] <= wdata_q[c*8 +: N];
				end
				default: begin
					for (int r = 0; r < N; r++) begin
						if (awaddr_q == prs_pkg::OFF_DEP_BASE + 8'(4 * r)) dep_q[r] <= wdata_q[N-1:0];
						if (awaddr_q == prs_pkg::OFF_DLY_BASE + 8'(4 * r)) dly_q[r] <= wdata_q; // [RULE24]
					end
				end
			endcase
		end
	end

	// axi read: one cycle to accept, data the next
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
			prs_pkg::OFF_CTRL: rd_mux = ctrl_q;
			prs_pkg::OFF_MIN_MASK: rd_mux = 32'(min_mask_q);
			prs_pkg::OFF_TIMER_REQ: rd_mux = 32'(timer_req_q);
			prs_pkg::OFF_STATUS: rd_mux = {16'h0000, 8'(pend_flag_q), 8'(on_flag_q)}; // [RULE24]
			prs_pkg::OFF_PIN: rd_mux = {28'h0000000, mode_q, short_range_radio_enable_pin,
				wireless_lan_enable_pin};
			default: begin
				for (int r = 0; r < N; r++) begin
					if (s_axi_araddr == prs_pkg::OFF_DEP_BASE + 8'(4 * r)) rd_mux = 32'(dep_q[r]);
					if (s_axi_araddr == prs_pkg::OFF_DLY_BASE + 8'(4 * r)) rd_mux = dly_q[r];
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= prs_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= (s_axi_araddr < prs_pkg::OFF_DLY_BASE + 8'(4 * N)) ?
					prs_pkg::RESP_OKAY : prs_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// checks
	AST_REG_ON: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
		any_pin |=> regulator_enable) else $error("regulators not enabled");
	AST_WL_RST: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
		!wireless_lan_enable_pin |=> !wlan_reset_n) else $error("wlan not held in reset");
	AST_TIMER_STABLE: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
		!pend_flag_q[CHK_RES] |-> timer_q[CHK_RES] == '0) else $error("timer nonzero while stable");
	AST_TIMER_BUSY: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
		pend_flag_q[CHK_RES] |-> timer_q[CHK_RES] != '0) else $error("timer zero while pending");
	AST_DEC: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
		tick_q && pend_flag_q[CHK_RES] && timer_q[CHK_RES] > DW'(1) |=>
		timer_q[CHK_RES] == $past(timer_q[CHK_RES]) - DW'(1)) else $error("timer did not decrement");
	AST_TOGGLE: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
		tick_q && pend_flag_q[CHK_RES] && timer_q[CHK_RES] == DW'(1) |=> !pend_flag_q[CHK_RES] &&
		on_flag_q[CHK_RES] != $past(on_flag_q[CHK_RES])) else $error("no toggle at timer end");
	AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE12]
		!tick_q |=> $stable(on_flag_q)) else $error("state moved off tick");
	AST_SAVE: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE17]
		retention_save |-> mode_q == prs_pkg::PM_SAVE ##1 mode_q == prs_pkg::PM_SLEEP)
		else $error("save not before sleep");
	AST_DOZE: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE16]
		mode_q == prs_pkg::PM_SLEEP |=> !main_clk_enable) else $error("main clock on in doze");
	COV_ON: cover property (@(posedge aclk) disable iff (!aresetn) $rose(on_flag_q[CHK_RES]));
	COV_OFF: cover property (@(posedge aclk) disable iff (!aresetn) $fell(on_flag_q[CHK_RES]));
	COV_WAKE: cover property (@(posedge aclk) disable iff (!aresetn) retention_restore);
endmodule

// [hdl/prs_pkg.sv]
/*
 * shared constants and register layout for the power resource sequencer.
 * assumes a 250 MHz bus clock and an AXI4-Lite master with 32-bit data.
 */
package prs_pkg;
	localparam int NUM_RES = 8;
	localparam int DLY_W = 16;
	localparam int CLK_HZ = 250000000;
	localparam int TICK_HZ = 32768;
	localparam int TICK_DIV = CLK_HZ / TICK_HZ;
	// register byte addresses
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MIN_MASK = 8'h04;
	localparam logic [7:0] OFF_CLK_MAP = 8'h08;
	localparam logic [7:0] OFF_TIMER_REQ = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_PIN = 8'h14;
	localparam logic [7:0] OFF_DEP_BASE = 8'h40;
	localparam logic [7:0] OFF_DLY_BASE = 8'h80;
	// control register fields
	localparam int CTRL_PD_WL = 0;
	localparam int CTRL_PD_SR = 1;
	localparam int CTRL_SLEEP = 2;
	localparam logic [31:0] CTRL_RST = 32'h0000_0003;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// resource index of each regulator
	localparam int RES_CORE_SWITCHING_REGULATOR_IDX = 0;
	localparam int RES_CORE_LDO_IDX = 1;
	localparam int RES_LN_LDO_IDX = 2;

	typedef enum logic [1:0] {
		RS_OFF = 2'b00,
		RS_GOING_ON = 2'b01,
		RS_ON = 2'b11,
		RS_GOING_OFF = 2'b10
	} res_state_e;

	typedef enum logic [1:0] {
		PM_OFF = 2'b00,
		PM_ACTIVE = 2'b01,
		PM_SAVE = 2'b10,
		PM_SLEEP = 2'b11
	} pm_mode_e;

	typedef struct packed {
		logic [DLY_W-1:0] on_dly;
		logic [DLY_W-1:0] off_dly;
	} res_dly_s;
endpackage

// [test/host_pin_model.sv]
/*
 * host side of one power-enable pin: drives the level it is told to, or lets go.
 * assumes the pull-down enable comes from the sequencer and pins sample on aclk.
 */
`timescale 1ns/1ns
module host_pin_model (
	input wire logic aclk,
	input wire logic drive,
	input wire logic level,
	input wire logic pulldown_on,
	output logic pin
);
	logic pin_q = 1'b0;

	// a released pin with no pull-down floats: toggle so a stale level never passes
	always @(posedge aclk) begin
		if (drive) begin
			pin_q <= level;
		end else if (pulldown_on) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= ~pin_q;
		end
	end
	assign pin = pin_q;
endmodule

// [test/power_resource_sequencer_tb.sv]
/*
 * self-checking bench: pins, registers, resource sequencing, doze and shutdown.
 * assumes host_pin_model for both pins and one sequencer step per TICK_DIV cycles.
 */
`timescale 1ns/1ns
module power_resource_sequencer_tb;
	localparam int TD = prs_pkg::TICK_DIV;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [3:0] clk_req = 4'h0;
	logic wake_event = 0, drv = 1, wl_lvl = 0, sr_lvl = 0, wl_pin, sr_pin;
	logic regulator_enable, wlan_reset_n, main_clk_enable, io_enable;
	logic retention_save, retention_restore, wl_pulldown_enable, sr_pulldown_enable;
	logic [7:0] resource_enable;
	int bad_count = 0;
	int n_compared = 0;

	always #2 aclk = ~aclk;

	power_resource_sequencer #(.NUM_CLK_REQ(4)) i_power_resource_sequencer (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.wireless_lan_enable_pin(wl_pin), .short_range_radio_enable_pin(sr_pin),
		.clk_req(clk_req), .wake_event(wake_event), .regulator_enable(regulator_enable),
		.wlan_reset_n(wlan_reset_n), .resource_enable(resource_enable),
		.main_clk_enable(main_clk_enable), .retention_save(retention_save),
		.retention_restore(retention_restore), .io_enable(io_enable),
		.wl_pulldown_enable(wl_pulldown_enable), .sr_pulldown_enable(sr_pulldown_enable));
	host_pin_model i_host_pin_model_wl (.aclk(aclk), .drive(drv), .level(wl_lvl),
		.pulldown_on(wl_pulldown_enable), .pin(wl_pin));
	host_pin_model i_host_pin_model_sr (.aclk(aclk), .drive(drv), .level(sr_lvl),
		.pulldown_on(sr_pulldown_enable), .pin(sr_pin));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task summarize;
		$display("mismatches %0d comparisons %0d", bad_count, n_compared);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// address and data offered together, each dropped once its own ready is seen
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_t, w_t;
		aw_t = 1'b0;
		w_t = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_t && w_t)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_t = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_t = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge aclk);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task rdr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		while (!arready) @(posedge aclk);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge aclk);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task pins(input logic wl, input logic sr);
		@(posedge aclk);
		wl_lvl <= wl;
		sr_lvl <= sr;
		repeat (4) @(posedge aclk);
	endtask

	// the wait is bounded at three sequencer steps; sleep and shutdown act on aclk, not on a step
	task automatic wait_for(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 3 * TD) begin
			@(posedge aclk);
			n++;
		end
		chk(s, v);
	endtask

	task t_reset;
		chk({wl_pulldown_enable, sr_pulldown_enable, regulator_enable, wlan_reset_n}, 4'hc);
		rdr(prs_pkg::OFF_CTRL);
		chk(rd, prs_pkg::CTRL_RST);
		rdr(8'ha0);
		chk(rd, 32'h0);
		chk(resp, prs_pkg::RESP_SLVERR);
		wr(8'hfc, 32'h1);
		chk(resp, prs_pkg::RESP_SLVERR);
		rdr(prs_pkg::OFF_STATUS);
		chk(rd, 32'h0);
	endtask

	task t_pins;
		for (int k = 1; k < 5; k++) begin
			pins(k[1], k[0]);
			chk(regulator_enable, k[1] | k[0]);
			chk(wlan_reset_n, k[1]);
			chk(resource_enable[0], k[1] | k[0]);
		end
	endtask

	// res3 timed on, res4 held by a request timer, res5 by a clock request needing res6
	task t_resource;
		logic seen;
		int t0;
		seen = 0;
		t0 = 0;
		rd = 0;
		pins(1, 0);
		wr(prs_pkg::OFF_DLY_BASE + 8'h0c, 32'h0002_0000);
		wr(prs_pkg::OFF_DLY_BASE + 8'h14, 32'h0);
		wr(prs_pkg::OFF_DLY_BASE + 8'h18, 32'h0);
		wr(prs_pkg::OFF_DEP_BASE + 8'h14, 32'h40);
		wr(prs_pkg::OFF_CLK_MAP, 32'h0000_2000);
		wr(prs_pkg::OFF_MIN_MASK, 32'h08);
		wr(prs_pkg::OFF_TIMER_REQ, 32'h10);
		clk_req <= 4'h2;
		for (int i = 0; i < 80 && !(rd[3] && !rd[11]); i++) begin
			repeat (500) @(posedge aclk);
			rdr(prs_pkg::OFF_STATUS);
			if (rd[11] && !seen) t0 = $time;
			seen |= rd[11];
			chk(rd[5] & ~rd[6], 0);
			chk(rd[14:12], 0);
		end
		chk(seen, 1);
		chk(($time - t0) / 4 > 2 * TD - 1100 && ($time - t0) / 4 < 2 * TD + 1100, 1);
		chk(rd[7:0] & 8'h78, 8'h78);
		chk(resource_enable & 8'h78, 8'h78);
		wr(prs_pkg::OFF_MIN_MASK, 32'h0);
		wr(prs_pkg::OFF_TIMER_REQ, 32'h0);
		clk_req <= 4'h0;
		for (int i = 0; i < 80 && (rd & 32'h7878) != 0; i++) begin
			repeat (500) @(posedge aclk);
			rdr(prs_pkg::OFF_STATUS);
			chk(rd[5] & ~rd[6], 0);
		end
		chk(rd & 32'h7878, 0);
		chk(resource_enable & 8'h78, 0);
	endtask

	task t_sleep;
		wr(prs_pkg::OFF_CTRL, 32'h7);
		wait_for(retention_save, 1);
		chk(main_clk_enable, 1);
		@(posedge aclk);
		chk(retention_save, 0);
		wr(prs_pkg::OFF_CTRL, prs_pkg::CTRL_RST);
		repeat (8) @(posedge aclk);
		chk(main_clk_enable, 0);
		wake_event <= 1'b1;
		wait_for(retention_restore, 1);
		wake_event <= 1'b0;
		@(posedge aclk);
		chk(retention_restore, 0);
		repeat (8) @(posedge aclk);
		chk(main_clk_enable, 1);
	endtask

	task t_shutdown;
		pins(0, 0);
		wait_for(io_enable, 0);
		chk({regulator_enable, main_clk_enable, wlan_reset_n}, 0);
		pins(0, 1);
		wait_for(io_enable, 1);
		chk({regulator_enable, wlan_reset_n}, 2'b10);
		drv <= 1'b0;
		repeat (4) @(posedge aclk);
		chk(regulator_enable, 0);
		drv <= 1'b1;
		wr(prs_pkg::OFF_CTRL, 32'h0);
		repeat (2) @(posedge aclk);
		chk({wl_pulldown_enable, sr_pulldown_enable}, 0);
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_pins;
		t_resource;
		t_sleep;
		t_shutdown;
		summarize;
	end

	// watchdog sized for about thirteen sequencer steps
	initial begin
		repeat (98000) @(posedge aclk);
		bad_count++;
		summarize;
	end
endmodule
